// ### logic/t8p_timer.sv
// 8-bit PWM timer with pre-scaler, scaler, interrupt and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

module t8p_timer #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, freeze
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // AXI4-Lite write address and data
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic [2:0]        s_awprot,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  // AXI4-Lite write response
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  output logic [1:0]             s_bresp,
  // AXI4-Lite read
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic [2:0]        s_arprot,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  // External clock source pins, asynchronous
  input  wire logic [1:0]        ext_clk_pins,
  // Waveform pins
  output logic                   first_output_pin,
  output logic                   first_output_pin_oe,
  output logic                   second_output_pin,
  output logic                   second_output_pin_oe,
  // Interrupt
  output logic                   irq
);

  // Elaboration check: the decoder reads address bits 7..2
  if (ADDR_W < t8p_pkg::MIN_ADDR_W) begin : g_addr_w_chk
    $error("ADDR_W too small for the register map");
  end

  // Register state
  t8p_pkg::t8p_ctrl_t  ctrl_q, ctrl_d;
  t8p_pkg::t8p_scale_t scale_q, scale_d;
  logic [7:0]          bound_q, bound_d;
  logic [7:0]          cnt_q, cnt_d;
  logic [5:0]          pre_q, pre_d;
  logic [4:0]          div_q, div_d;
  logic                wave_q, wave_d;
  logic                stat_q, stat_d;
  logic                mask_q, mask_d;
  // Bus state
  logic                aw_have_q, aw_have_d;
  logic                w_have_q, w_have_d;
  logic [7:0]          awaddr_q, awaddr_d;
  logic [7:0]          wdata_q, wdata_d;
  logic                wstrb0_q, wstrb0_d;
  logic                bvalid_q, bvalid_d;
  logic [1:0]          bresp_q, bresp_d;
  logic                rvalid_q, rvalid_d;
  logic [31:0]         rdata_q, rdata_d;
  logic [1:0]          rresp_q, rresp_d;
  // Synchronisers
  logic [1:0]          ext_s1_q, ext_s2_q, ext_s3_q;
  // Combinational helpers
  t8p_pkg::t8p_wr_t    wr;
  t8p_pkg::t8p_mode_t  mode;
  logic                src_tick, pre_hit, cnt_tick, at_top, bound_hit;
  logic [7:0]          top;
  logic [1:0]          ext_rise;

  // Decode a word-aligned byte address
  function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
    word_addr = {a[7:2], 2'b00};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == t8p_pkg::OFF_CTRL) || (a == t8p_pkg::OFF_BOUND) ||
             (a == t8p_pkg::OFF_SCALE) || (a == t8p_pkg::OFF_COUNT) ||
             (a == t8p_pkg::OFF_STATUS) || (a == t8p_pkg::OFF_MASK);
  endfunction

  // Ready only while clk_en is high, so a frozen slave never loses a beat
  assign s_awready = clk_en && !aw_have_q && !bvalid_q;
  assign s_wready  = clk_en && !w_have_q && !bvalid_q;
  assign s_arready = clk_en && !rvalid_q;
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;
  assign s_rvalid  = rvalid_q;
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

  // Bus handshakes; address and data may come in either order
  always_comb begin
    logic       aw_ok;
    logic       w_ok;
    logic [7:0] ra;
    aw_ok     = aw_have_q || (s_awvalid && s_awready);
    w_ok      = w_have_q || (s_wvalid && s_wready);
    ra        = word_addr(s_araddr);
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    wr        = '0;
    if (s_awvalid && s_awready) begin
      aw_have_d = 1'b1;
      awaddr_d  = word_addr(s_awaddr);
    end
    if (s_wvalid && s_wready) begin
      w_have_d = 1'b1;
      wdata_d  = s_wdata[7:0];
      wstrb0_d = s_wstrb[0];
    end
    if (clk_en && aw_ok && w_ok && !bvalid_q) begin
      wr.addr   = aw_have_q ? awaddr_q : word_addr(s_awaddr);
      wr.data   = w_have_q ? wdata_q : s_wdata[7:0];
      wr.en     = (w_have_q ? wstrb0_q : s_wstrb[0]) && mapped(wr.addr);
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(wr.addr) ? t8p_pkg::RESP_OKAY : t8p_pkg::RESP_SLVERR;
    end else if (clk_en && bvalid_q && s_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(ra) ? t8p_pkg::RESP_OKAY : t8p_pkg::RESP_SLVERR;
      rdata_d  = 32'h0000_0000;
      if (ra == t8p_pkg::OFF_CTRL) begin
        rdata_d[7:0] = ctrl_q;
      end else if (ra == t8p_pkg::OFF_BOUND) begin
        rdata_d[7:0] = bound_q;
      end else if (ra == t8p_pkg::OFF_SCALE) begin
        rdata_d[7:0] = scale_q;
      end else if (ra == t8p_pkg::OFF_COUNT) begin
        rdata_d[7:0] = cnt_q;
      end else if (ra == t8p_pkg::OFF_STATUS) begin
        rdata_d[0] = stat_q;
      end else if (ra == t8p_pkg::OFF_MASK) begin
        rdata_d[0] = mask_q;
      end
    end else if (clk_en && rvalid_q && s_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= t8p_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= t8p_pkg::RESP_OKAY;
    end else if (clk_en) begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // External source pins: two stages, then a third for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_q <= 2'h0;
      ext_s2_q <= 2'h0;
      ext_s3_q <= 2'h0;
    end else if (clk_en) begin
      ext_s1_q <= ext_clk_pins;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_rise = ext_s2_q & ~ext_s3_q;

  // Timer datapath and register writes
  always_comb begin
    // Mode from PWM enable and resolution bit
    if (!ctrl_q.pwm) begin
      mode = t8p_pkg::MODE_PERIOD;
    end else if (!scale_q.res6) begin
      mode = t8p_pkg::MODE_PWM8;
    end else begin
      mode = t8p_pkg::MODE_PWM6;
    end
    // Source select; stop and unused codes give no ticks
    case (ctrl_q.src)
      t8p_pkg::SRC_SYS:  src_tick = 1'b1;
      t8p_pkg::SRC_EXT0: src_tick = ext_rise[0];
      t8p_pkg::SRC_EXT1: src_tick = ext_rise[1];
      default:           src_tick = 1'b0;
    endcase
    // Free-running pre-scaler; masked all-ones marks the divided tick
    case (scale_q.pre)
      t8p_pkg::PRE_DIV1:  pre_hit = 1'b1;
      t8p_pkg::PRE_DIV4:  pre_hit = &pre_q[1:0];
      t8p_pkg::PRE_DIV16: pre_hit = &pre_q[3:0];
      default:            pre_hit = &pre_q[5:0];
    endcase
    pre_d    = src_tick ? pre_q + 6'h01 : pre_q;
    div_d    = div_q;
    cnt_tick = 1'b0;
    if (src_tick && pre_hit) begin
      if (div_q >= scale_q.div) begin
        div_d    = 5'h00;
        cnt_tick = 1'b1;
      end else begin
        div_d = div_q + 5'h01;
      end
    end
    // Wrap point: bound in period mode, full range in PWM
    case (mode)
      t8p_pkg::MODE_PERIOD: top = bound_q;
      t8p_pkg::MODE_PWM8:   top = t8p_pkg::TOP_PWM8;
      default:              top = t8p_pkg::TOP_PWM6;
    endcase
    // At or above the top also wraps, so a bound lowered mid-count recovers at once
    at_top    = cnt_q >= top;
    bound_hit = (mode == t8p_pkg::MODE_PWM6) ? (cnt_q[5:0] == bound_q[5:0]) : (cnt_q == bound_q);
    cnt_d     = cnt_q;
    wave_d    = wave_q;
    if (cnt_tick) begin
      cnt_d = at_top ? 8'h00 : cnt_q + 8'h01;
      case (mode)
        t8p_pkg::MODE_PERIOD: wave_d = at_top ? !wave_q : wave_q;
        t8p_pkg::MODE_PWM8:   wave_d = cnt_d <= bound_q;
        default:              wave_d = cnt_d[5:0] <= bound_q[5:0];
      endcase
    end
    ctrl_d  = ctrl_q;
    bound_d = bound_q;
    scale_d = scale_q;
    mask_d  = mask_q;
    stat_d  = stat_q;
    if (wr.en) begin
      if (wr.addr == t8p_pkg::OFF_CTRL) begin
        ctrl_d = wr.data;
      end else if (wr.addr == t8p_pkg::OFF_BOUND) begin
        bound_d = wr.data;
      end else if (wr.addr == t8p_pkg::OFF_SCALE) begin
        scale_d = wr.data;
      end else if (wr.addr == t8p_pkg::OFF_COUNT) begin
        cnt_d = wr.data;
      end else if (wr.addr == t8p_pkg::OFF_STATUS) begin
        stat_d = stat_q && !wr.data[0];
      end else if (wr.addr == t8p_pkg::OFF_MASK) begin
        mask_d = wr.data[0];
      end
    end
    // Set after clear, so an event in the clearing cycle survives
    if (cnt_tick && bound_hit) begin
      stat_d = 1'b1;
    end
  end

  // Timer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= t8p_pkg::RST_CTRL;
      bound_q <= t8p_pkg::RST_BOUND;
      scale_q <= t8p_pkg::RST_SCALE;
      cnt_q   <= t8p_pkg::RST_COUNT;
      pre_q   <= 6'h00;
      div_q   <= 5'h00;
      wave_q  <= 1'b0;
      stat_q  <= 1'b0;
      mask_q  <= 1'b0;
    end else if (clk_en) begin
      ctrl_q  <= ctrl_d;
      bound_q <= bound_d;
      scale_q <= scale_d;
      cnt_q   <= cnt_d;
      pre_q   <= pre_d;
      div_q   <= div_d;
      wave_q  <= wave_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
    end
  end

  // Pin drive ignores the pin's own direction setting
  assign first_output_pin     = wave_q;
  assign second_output_pin    = wave_q;
  assign first_output_pin_oe  = ctrl_q.pin == t8p_pkg::PIN_FIRST;
  assign second_output_pin_oe = ctrl_q.pin == t8p_pkg::PIN_SECOND;
  assign irq                  = stat_q && mask_q;

endmodule

`default_nettype wire

// ### logic/t8p_pkg.sv
// Package: register map, field layout and modes of the 8-bit PWM timer
package t8p_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_BOUND  = 8'h04;
  localparam logic [7:0] OFF_SCALE  = 8'h08;
  localparam logic [7:0] OFF_COUNT  = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK   = 8'h14;
  // Reset values
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_BOUND  = 8'h00;
  localparam logic [7:0] RST_SCALE  = 8'h00;
  localparam logic [7:0] RST_COUNT  = 8'h00;
  // Clock source codes in control bits 7..4
  localparam logic [3:0] SRC_STOP   = 4'h0;
  localparam logic [3:0] SRC_SYS    = 4'h1;
  localparam logic [3:0] SRC_EXT0   = 4'h2;
  localparam logic [3:0] SRC_EXT1   = 4'h3;
  // Output pin select codes in control bits 3..2
  localparam logic [1:0] PIN_FIRST  = 2'h2;
  localparam logic [1:0] PIN_SECOND = 2'h3;
  // Pre-scaler codes in scale bits 6..5
  localparam logic [1:0] PRE_DIV1   = 2'h0;
  localparam logic [1:0] PRE_DIV4   = 2'h1;
  localparam logic [1:0] PRE_DIV16  = 2'h2;
  localparam logic [1:0] PRE_DIV64  = 2'h3;
  // Counter tops in the two PWM resolutions
  localparam logic [7:0] TOP_PWM8   = 8'hff;
  localparam logic [7:0] TOP_PWM6   = 8'h3f;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         MIN_ADDR_W  = 8;

  typedef enum logic [1:0] {
    MODE_PERIOD,
    MODE_PWM8,
    MODE_PWM6
  } t8p_mode_t;

  // Control register layout
  typedef struct packed {
    logic [3:0] src;
    logic [1:0] pin;
    logic       pwm;
    logic       rsvd;
  } t8p_ctrl_t;

  // Scale register layout
  typedef struct packed {
    logic       res6;
    logic [1:0] pre;
    logic [4:0] div;
  } t8p_scale_t;

  // One register write handed from the bus to the timer
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } t8p_wr_t;
endpackage

// ### testbench/t8p_pin_model.sv
// Pin-side observer that measures the timer waveform
`timescale 1ns/1ps
`default_nettype none
module t8p_pin_model (
  // Clock
  input  wire logic        aclk,
  // Pin and its enable
  input  wire logic        pin,
  input  wire logic        pin_oe,
  // Last whole cycle in clock periods, and the pin level
  output logic      [31:0] period,
  output logic      [31:0] high_len,
  output logic             level
);
  logic        prev = 1'b0;
  logic [31:0] cnt  = 32'h0;
  logic [31:0] hcnt = 32'h0;
  // A pull-down keeps a released pin low, so a stale level never shows
  assign level = pin_oe ? pin : 1'b0;
  // Period and high time restart at each rising edge
  always @(posedge aclk) begin
    if (level && !prev) begin
      period   <= cnt;
      high_len <= hcnt;
      cnt      <= 32'h1;
      hcnt     <= 32'h1;
    end else begin
      cnt  <= cnt + 32'h1;
      hcnt <= hcnt + {31'h0, level};
    end
    prev <= level;
  end
endmodule
`default_nettype wire

// ### testbench/t8p_timer_chk.sv
// Port-level assertions for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module t8p_timer_chk (
  // Clock and control
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // Bus handshakes
  input  wire logic        s_awvalid,
  input  wire logic        s_awready,
  input  wire logic        s_wvalid,
  input  wire logic        s_wready,
  input  wire logic        s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [1:0]  s_bresp,
  input  wire logic        s_arvalid,
  input  wire logic        s_arready,
  input  wire logic        s_rvalid,
  input  wire logic        s_rready,
  input  wire logic [31:0] s_rdata,
  // Pins
  input  wire logic        first_output_pin,
  input  wire logic        first_output_pin_oe,
  input  wire logic        second_output_pin,
  input  wire logic        second_output_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Requests must be answered, and responses must stand until taken
  bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  wr_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready |=> s_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid ##0 s_rdata[31:8] == 24'h0)
    else $error("read not answered");
  // Freezing must stall the bus and the waveform alike; the pins must agree and never both be enabled
  bus_freeze_a: assert property (!clk_en |-> !s_awready && !s_wready && !s_arready)
    else $error("bus ready while frozen");
  pin_freeze_a: assert property (!clk_en |=> $stable(first_output_pin))
    else $error("pin moved while frozen");
  pin_mirror_a: assert property (first_output_pin == second_output_pin)
    else $error("pins disagree");
  oe_excl_a: assert property (!(first_output_pin_oe && second_output_pin_oe))
    else $error("both pins enabled");
endmodule
`default_nettype wire

// ### testbench/t8p_timer_tb_top.sv
// Self-checking bench for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module t8p_timer_tb_top;
  logic        aclk, aresetn, clk_en, irq, level;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, period, high_len, acc;
  logic [1:0]  s_bresp, s_rresp;
  logic        first_output_pin, first_output_pin_oe, second_output_pin, second_output_pin_oe;
  logic [1:0]  ext_pins = 2'h0;
  int          fail_count = 0;
  int          checks_done = 0;

  t8p_timer uut (.aclk, .aresetn, .clk_en, .s_awvalid, .s_awready, .s_awaddr, .s_awprot(3'h0),
    .s_wvalid, .s_wready, .s_wdata, .s_wstrb(4'hf), .s_bvalid, .s_bready, .s_bresp, .s_arvalid,
    .s_arready, .s_araddr, .s_arprot(3'h0), .s_rvalid, .s_rready, .s_rdata, .s_rresp,
    .ext_clk_pins(ext_pins), .first_output_pin, .first_output_pin_oe, .second_output_pin,
    .second_output_pin_oe, .irq);
  t8p_pin_model pm (.aclk, .pin(first_output_pin), .pin_oe(first_output_pin_oe), .period, .high_len, .level);

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // External source pins: a rising edge every six cycles on both
  initial begin
    forever begin
      repeat (3) @(posedge aclk);
      ext_pins <= ~ext_pins;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_awvalid <= 1'b1;
    s_awaddr  <= a;
    s_wvalid  <= 1'b1;
    s_wdata   <= {24'h0, d};
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) begin ad = 1'b1; s_awvalid <= 1'b0; end
      if (s_wvalid && s_wready) begin wd = 1'b1; s_wvalid <= 1'b0; end
    end
    // Ready raised only once the response shows, so the slave must hold it a cycle
    do @(posedge aclk); while (!s_bvalid);
    s_bready <= 1'b1;
    @(posedge aclk);
    chk({30'h0, s_bresp}, 32'h0);
    s_bready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_arvalid <= 1'b1;
    s_araddr  <= a;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    // Data taken at the edge where rvalid and rready are both high
    do @(posedge aclk); while (!s_rvalid);
    s_rready <= 1'b1;
    @(posedge aclk);
    chk(s_rdata, exp);
    chk({30'h0, s_rresp}, {30'h0, er});
    s_rready <= 1'b0;
  endtask

  // Configure, let the wave settle, then compare period and high time
  task automatic wave(input logic [7:0] c, b, s, input logic [31:0] p, h);
    wr(t8p_pkg::OFF_BOUND, b); wr(t8p_pkg::OFF_SCALE, s); wr(t8p_pkg::OFF_CTRL, c);
    repeat (3 * p + 40) @(posedge aclk);
    chk(period, p);
    chk(high_len, h);
    $display("wave test done");
  endtask

  // Full duty has no rising edge to time, so count high samples over one period
  task automatic full(input logic [7:0] b, s, input logic [31:0] n);
    wr(t8p_pkg::OFF_BOUND, b);
    wr(t8p_pkg::OFF_SCALE, s);
    repeat (300) @(posedge aclk);
    acc = 32'h0;
    repeat (n) begin
      @(posedge aclk);
      acc = acc + {31'h0, level};
    end
    chk(acc, n);
    $display("full duty test done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog: the tests take a few thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    conclude;
  end

  initial begin
    aresetn = 1'b0; clk_en = 1'b1; s_awvalid = 1'b0; s_wvalid = 1'b0; s_bready = 1'b0; s_arvalid = 1'b0;
    s_rready = 1'b0; s_awaddr = 8'h0; s_araddr = 8'h0; s_wdata = 32'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(t8p_pkg::OFF_CTRL, 32'h0, 2'h0);
    rdc(t8p_pkg::OFF_SCALE, 32'h0, 2'h0);
    rdc(t8p_pkg::OFF_COUNT, 32'h0, 2'h0);
    rdc(8'h40, 32'h0, t8p_pkg::RESP_SLVERR);
    $display("reset test done");
    wave(8'h18, 8'h03, 8'h00, 32'd8, 32'd4);
    wave(8'h18, 8'h03, 8'h21, 32'd64, 32'd32);
    clk_en <= 1'b0;
    repeat (6) @(posedge aclk);
    clk_en <= 1'b1;
    wave(8'h1a, 8'h09, 8'h00, 32'd256, 32'd10);
    wave(8'h1a, 8'h00, 8'h80, 32'd64, 32'd1);
    // Full duty: the pin never falls
    full(8'h3f, 8'h80, 32'd64);
    full(8'hff, 8'h00, 32'd256);
    // Interrupt: set, masked, unmasked, cleared
    rdc(t8p_pkg::OFF_STATUS, 32'h1, 2'h0);
    chk({31'h0, irq}, 32'h0);
    wr(t8p_pkg::OFF_MASK, 8'h01);
    chk({31'h0, irq}, 32'h1);
    wr(t8p_pkg::OFF_CTRL, 8'h08);
    wr(t8p_pkg::OFF_STATUS, 8'h01);
    rdc(t8p_pkg::OFF_STATUS, 32'h0, 2'h0);
    chk({31'h0, irq}, 32'h0);
    // Stopped counter keeps a software value and the pin level
    wr(t8p_pkg::OFF_COUNT, 8'h05);
    repeat (50) @(posedge aclk);
    rdc(t8p_pkg::OFF_COUNT, 32'h5, 2'h0);
    chk({31'h0, level}, 32'h1);
    wr(t8p_pkg::OFF_CTRL, 8'h0c);
    chk({30'h0, first_output_pin_oe, second_output_pin_oe}, 32'h1);
    $display("register test done");
    // External sources at bound 0: each synchronised rising edge toggles the pin
    wave(8'h28, 8'h00, 8'h00, 32'd12, 32'd6);
    wave(8'h38, 8'h00, 8'h00, 32'd12, 32'd6);
    conclude;
  end
endmodule

bind t8p_timer t8p_timer_chk u_chk (.aclk, .aresetn, .clk_en, .s_awvalid, .s_awready, .s_wvalid,
  .s_wready, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata,
  .first_output_pin, .first_output_pin_oe, .second_output_pin, .second_output_pin_oe);
`default_nettype wire
